// ===== rtl/cgwd_ctrl.sv
// rtl: control logic of the clock generator (spread, watchdog, power-down)
// Functional notes
// - spread modulation on or off follows control byte 1 bit 7
// - mode bit and two-bit type decode to down or center spread depth
// - dial change applies new frequency in the same cycle the watchdog starts counting
// - timeout selection rewritten to zero before expiry stops watchdog, no reset
// - new soft frequency select value also starts the watchdog
// - expiry drives low reset pulse and sets timeout flag
// - strap one selects differential mode, zero selects open-drain mode
// - differential: pd low on two edges holds other clocks low at fall
// - differential power-down: true host clock high, complement undriven
// - reference clock stop may take more than one of its cycles
// - differential: clocks running within 3 ms of pd release
// - open-drain: pd low on two edges stops all outputs low promptly
// - open-drain power-down: synthesizers, oscillator, management bus off
// - open-drain: restart at rising edge of next full period
// - only first falling edge of power-good counts, then ignored
// - timeout code zero disables, one to fifteen give that many seconds
// - timeout flag clears when selection bits are cleared
// - after watchdog reboot, revert bit picks strap or previous soft setting
`timescale 1ns/1ps
`default_nettype none
module cgwd_ctrl
	import cgwd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = cgwd_pkg::WD_TICK_CYCLES,
	parameter int unsigned PWRUP_CYCLES = cgwd_pkg::PWRUP_LAT_CYCLES,
	parameter int unsigned RST_PULSE = cgwd_pkg::RESET_PULSE_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic host_clk_in,
	input wire logic [7:0] ctrl_byte1,
	input wire logic spread_mode,
	input wire logic spread_type_hi,
	input wire logic spread_type_lo,
	input wire logic [cgwd_pkg::WD_SEL_W-1:0] watchdog_timeout_sel,
	input wire logic [cgwd_pkg::FREQ_SEL_W-1:0] soft_freq_select,
	input wire logic [cgwd_pkg::DIAL_W-1:0] fine_freq_dial,
	input wire logic freq_revert_sel,
	input wire logic [cgwd_pkg::FREQ_SEL_W-1:0] strap_freq,
	input wire logic processor_family_strap,
	input wire logic power_down_n,
	input wire logic term_supply_good_n,
	output logic spread_enable,
	output logic spread_center,
	output logic [7:0] spread_depth,
	output logic [cgwd_pkg::FREQ_SEL_W-1:0] active_freq_sel,
	output logic [cgwd_pkg::DIAL_W-1:0] active_dial,
	output logic system_reset_out_n,
	output logic watchdog_timeout_flag,
	output logic clocks_gate_n,
	output logic host_true_hold_high,
	output logic host_comp_oe,
	output logic synth_enable,
	output logic osc_enable,
	output logic mgmt_enable,
	output logic clocks_running,
	output logic power_good_seen
);
	// ************************************************************
	// reset release and input synchronisers
	// ************************************************************
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// two flops each; only stage two is read
	logic [2:0] s1_q, s2_q, s1_d, s2_d;
	logic hclk_prev_q, hclk_prev_d;
	always_comb
	begin
		s1_d = {host_clk_in, power_down_n, term_supply_good_n};
		s2_d = s1_q;
		hclk_prev_d = s2_q[2];
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 3'h3;
			s2_q <= 3'h3;
			hclk_prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			hclk_prev_q <= hclk_prev_d;
		end
	end
	logic hclk_s, pd_n_s, pg_n_s, hclk_rise, hclk_fall;
	assign hclk_s = s2_q[2];
	assign pd_n_s = s2_q[1];
	assign pg_n_s = s2_q[0];
	assign hclk_rise = hclk_s & ~hclk_prev_q;
	assign hclk_fall = ~hclk_s & hclk_prev_q;

	// ************************************************************
	// spread spectrum decode
	// ************************************************************
	function automatic logic [7:0] spread_lut(input logic center, input logic [1:0] code);
		logic [7:0] v;
		v = 8'h00;
		case ({center, code})
			3'h0: v = SPREAD_DOWN_150;
			3'h1: v = SPREAD_DOWN_100;
			3'h2: v = SPREAD_DOWN_070;
			3'h3: v = SPREAD_DOWN_050;
			3'h4: v = SPREAD_CTR_075;
			3'h5: v = SPREAD_CTR_050;
			3'h6: v = SPREAD_CTR_035;
			default: v = SPREAD_CTR_025;
		endcase
		return v;
	endfunction : spread_lut

	logic ss_en_q, ss_en_d, ss_ctr_q, ss_ctr_d;
	logic [7:0] ss_depth_q, ss_depth_d;
	always_comb
	begin
		ss_en_d = ctrl_byte1[SS_ENABLE_BIT];
		ss_ctr_d = spread_mode;
		ss_depth_d = spread_lut(spread_mode, {spread_type_hi, spread_type_lo});
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ss_en_q <= 1'b0;
			ss_ctr_q <= 1'b0;
			ss_depth_q <= SPREAD_DOWN_150;
		end
		else
		begin
			ss_en_q <= ss_en_d;
			ss_ctr_q <= ss_ctr_d;
			ss_depth_q <= ss_depth_d;
		end
	end
	assign spread_enable = ss_en_q;
	assign spread_center = ss_ctr_q;
	assign spread_depth = ss_depth_q;

	// ************************************************************
	// watchdog self-recovery
	// ************************************************************
	cgwd_wd_state_t wd_q, wd_d;
	logic [31:0] tick_q, tick_d;
	logic [3:0] secs_q, secs_d;
	logic [15:0] pulse_q, pulse_d;
	logic flag_q, flag_d, rst_out_q, rst_out_d;
	logic [3:0] soft_freq_select_q, soft_freq_select_d, soft_freq_select_prev_q, soft_freq_select_prev_d, last_soft_q, last_soft_d;
	logic [DIAL_W-1:0] dial_q, dial_d, dial_seen_q, dial_seen_d;
	logic [3:0] soft_seen_q, soft_seen_d;
	logic change;
	always_comb
	begin
		wd_d = wd_q;
		tick_d = tick_q;
		secs_d = secs_q;
		pulse_d = pulse_q;
		flag_d = flag_q;
		rst_out_d = 1'b1;
		soft_freq_select_d = soft_freq_select_q;
		soft_freq_select_prev_d = soft_freq_select_prev_q;
		last_soft_d = last_soft_q;
		dial_d = dial_q;
		dial_seen_d = fine_freq_dial;
		soft_seen_d = soft_freq_select;
		change = (fine_freq_dial != dial_seen_q) || (soft_freq_select != soft_seen_q);
		// the new frequency is applied in the same cycle the timer is armed
		if (change)
		begin
			dial_d = fine_freq_dial;
			soft_freq_select_prev_d = last_soft_q;
			soft_freq_select_d = soft_freq_select;
			last_soft_d = soft_freq_select;
		end
		if (watchdog_timeout_sel == WD_SEL_OFF)
			flag_d = 1'b0;
		case (wd_q)
			WD_IDLE:
				if (change && watchdog_timeout_sel != WD_SEL_OFF)
				begin
					wd_d = WD_RUN;
					tick_d = 32'h0;
					secs_d = 4'h0;
				end
			WD_RUN:
				if (watchdog_timeout_sel == WD_SEL_OFF)
					wd_d = WD_IDLE;
				else if (tick_q == 32'(TICK_CYCLES - 1))
				begin
					tick_d = 32'h0;
					secs_d = secs_q + 4'h1;
					if (secs_q + 4'h1 >= watchdog_timeout_sel)
					begin
						wd_d = WD_FIRE;
						pulse_d = 16'h0;
						flag_d = 1'b1;
					end
				end
				else
					tick_d = tick_q + 32'h1;
			WD_FIRE:
			begin
				rst_out_d = 1'b0;
				pulse_d = pulse_q + 16'h1;
				// low is held through this last count, so the pulse is RST_PULSE cycles wide
				if (pulse_q == 16'(RST_PULSE - 1))
				begin
					wd_d = WD_DONE;
					soft_freq_select_d = freq_revert_sel ? soft_freq_select_prev_q : strap_freq;
				end
			end
			WD_DONE:
				if (change && watchdog_timeout_sel != WD_SEL_OFF)
				begin
					wd_d = WD_RUN;
					tick_d = 32'h0;
					secs_d = 4'h0;
				end
			default: wd_d = WD_IDLE;
		endcase
		// a flag set this cycle wins over a clear
		if (wd_q == WD_RUN && wd_d == WD_FIRE)
			flag_d = 1'b1;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_q <= WD_IDLE;
			tick_q <= 32'h0;
			secs_q <= 4'h0;
			pulse_q <= 16'h0;
			flag_q <= 1'b0;
			rst_out_q <= 1'b1;
			soft_freq_select_q <= STRAP_FREQ_RST;
			soft_freq_select_prev_q <= STRAP_FREQ_RST;
			last_soft_q <= 4'h0;
			dial_q <= '0;
			dial_seen_q <= '0;
			soft_seen_q <= 4'h0;
		end
		else
		begin
			wd_q <= wd_d;
			tick_q <= tick_d;
			secs_q <= secs_d;
			pulse_q <= pulse_d;
			flag_q <= flag_d;
			rst_out_q <= rst_out_d;
			soft_freq_select_q <= soft_freq_select_d;
			soft_freq_select_prev_q <= soft_freq_select_prev_d;
			last_soft_q <= last_soft_d;
			dial_q <= dial_d;
			dial_seen_q <= dial_seen_d;
			soft_seen_q <= soft_seen_d;
		end
	end
	assign system_reset_out_n = rst_out_q;
	assign watchdog_timeout_flag = flag_q;
	assign active_freq_sel = soft_freq_select_q;
	assign active_dial = dial_q;

	// ************************************************************
	// power-down sequencing
	// ************************************************************
	cgwd_pd_state_t pd_q, pd_d;
	logic [1:0] low_cnt_q, low_cnt_d;
	logic [31:0] lat_q, lat_d;
	logic pg_seen_q, pg_seen_d, pg_prev_q, pg_prev_d, mode_q, mode_d, mode_cap_q;
	logic gate_n_q, gate_n_d, hold_q, hold_d, comp_oe_q, comp_oe_d;
	logic synth_q, synth_d, run_q, run_d;
	always_comb
	begin
		pd_d = pd_q;
		low_cnt_d = low_cnt_q;
		lat_d = lat_q;
		gate_n_d = gate_n_q;
		hold_d = hold_q;
		comp_oe_d = comp_oe_q;
		synth_d = synth_q;
		run_d = run_q;
		pg_prev_d = pg_n_s;
		pg_seen_d = pg_seen_q;
		mode_d = mode_q;
		// first falling edge only; later edges ignored
		if (!pg_seen_q && pg_prev_q && !pg_n_s)
			pg_seen_d = 1'b1;
		if (!mode_cap_q)
			mode_d = processor_family_strap;
		// two consecutive host-clock rising edges with pd low
		if (hclk_rise)
			low_cnt_d = pd_n_s ? 2'h0 : (low_cnt_q == 2'h2 ? 2'h2 : low_cnt_q + 2'h1);
		case (pd_q)
			PD_RUN:
				if (low_cnt_q == 2'h2)
				begin
					pd_d = PD_STOPPING;
					run_d = 1'b0;
				end
			PD_STOPPING:
				// differential gates at a falling edge so no pulse is cut, may span cycles; open-drain gates at once
				if (hclk_fall || !mode_q)
				begin
					gate_n_d = 1'b0;
					pd_d = PD_DOWN;
					if (mode_q)
					begin
						hold_d = 1'b1;
						comp_oe_d = 1'b0;
					end
					else
						synth_d = 1'b0;
				end
			PD_DOWN:
				if (pd_n_s)
				begin
					pd_d = PD_RESUME;
					lat_d = 32'h0;
					synth_d = 1'b1;
					low_cnt_d = 2'h0;
				end
			PD_RESUME:
				if (!mode_q)
					pd_d = PD_ALIGN;
				else if (lat_q >= 32'(RESUME_CYCLES) || lat_q == 32'(PWRUP_CYCLES - 1))
				begin
					pd_d = PD_ALIGN;
				end
				else
					lat_d = lat_q + 32'h1;
			PD_ALIGN:
				// restart on a rising edge so the first pulse is full
				if (hclk_rise)
				begin
					gate_n_d = 1'b1;
					hold_d = 1'b0;
					comp_oe_d = 1'b1;
					run_d = 1'b1;
					pd_d = PD_RUN;
				end
			default: pd_d = PD_RUN;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pd_q <= PD_RUN;
			low_cnt_q <= 2'h0;
			lat_q <= 32'h0;
			gate_n_q <= 1'b1;
			hold_q <= 1'b0;
			comp_oe_q <= 1'b1;
			synth_q <= 1'b1;
			run_q <= 1'b1;
			pg_prev_q <= 1'b1;
			pg_seen_q <= 1'b0;
			mode_q <= 1'b1;
			mode_cap_q <= 1'b0;
		end
		else
		begin
			pd_q <= pd_d;
			low_cnt_q <= low_cnt_d;
			lat_q <= lat_d;
			gate_n_q <= gate_n_d;
			hold_q <= hold_d;
			comp_oe_q <= comp_oe_d;
			synth_q <= synth_d;
			run_q <= run_d;
			pg_prev_q <= pg_prev_d;
			pg_seen_q <= pg_seen_d;
			mode_q <= mode_d;
			mode_cap_q <= 1'b1;
		end
	end
	assign clocks_gate_n = gate_n_q;
	assign host_true_hold_high = hold_q;
	assign host_comp_oe = comp_oe_q;
	assign synth_enable = synth_q;
	assign osc_enable = synth_q;
	assign mgmt_enable = synth_q;
	assign clocks_running = run_q;
	assign power_good_seen = pg_seen_q;
endmodule : cgwd_ctrl
`default_nettype wire

// ===== shared/cgwd_pkg.sv
// package: constants and types for the clock generator control block
`default_nettype none
package cgwd_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned WD_TICK_S = 1;
	localparam int unsigned WD_TICK_CYCLES = CLK_HZ * WD_TICK_S;
	localparam int unsigned RESET_PULSE_CYCLES = 64;
	localparam int unsigned PWRUP_LAT_US = 3000;
	localparam int unsigned PWRUP_LAT_CYCLES = (CLK_HZ / 1000000) * PWRUP_LAT_US;
	localparam int unsigned RESUME_CYCLES = 256;
	// ************************************************************
	// field layouts
	// ************************************************************
	localparam int unsigned SS_ENABLE_BIT = 7;
	localparam int unsigned WD_SEL_W = 4;
	localparam logic [3:0] WD_SEL_OFF = 4'h0;
	localparam int unsigned FREQ_SEL_W = 4;
	localparam int unsigned DIAL_W = 14;
	localparam int unsigned SPREAD_W = 4;
	localparam logic [3:0] STRAP_FREQ_RST = 4'h0;
	// spread codes, hundredths of a percent magnitude
	localparam logic [7:0] SPREAD_DOWN_150 = 8'h96;
	localparam logic [7:0] SPREAD_DOWN_100 = 8'h64;
	localparam logic [7:0] SPREAD_DOWN_070 = 8'h46;
	localparam logic [7:0] SPREAD_DOWN_050 = 8'h32;
	localparam logic [7:0] SPREAD_CTR_075 = 8'h4B;
	localparam logic [7:0] SPREAD_CTR_050 = 8'h32;
	localparam logic [7:0] SPREAD_CTR_035 = 8'h23;
	localparam logic [7:0] SPREAD_CTR_025 = 8'h19;
	// ************************************************************
	// states
	// ************************************************************
	typedef enum logic [3:0] {
		WD_IDLE = 4'h1,
		WD_RUN = 4'h2,
		WD_FIRE = 4'h4,
		WD_DONE = 4'h8
	} cgwd_wd_state_t;
	typedef enum logic [4:0] {
		PD_RUN = 5'h01,
		PD_STOPPING = 5'h02,
		PD_DOWN = 5'h04,
		PD_RESUME = 5'h08,
		PD_ALIGN = 5'h10
	} cgwd_pd_state_t;
endpackage : cgwd_pkg
`default_nettype wire

// ===== verif/cgwd_host_model.sv
// partner model: host clock source at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module cgwd_host_model
#(
	parameter real HALF_NS = 80.0
)
(
	output logic host_clk
);
	// free-running host clock; odd start offset keeps it out of phase with clk
	initial
	begin
		host_clk = 1'b0;
		#7.3;
		forever #(HALF_NS) host_clk = ~host_clk;
	end
endmodule : cgwd_host_model
`default_nettype wire

// ===== verif/cgwd_ctrl_chk.sv
// checker: concurrent assertions on the clock generator control ports
`timescale 1ns/1ps
`default_nettype none
module cgwd_ctrl_chk
#(
	parameter int unsigned RST_PULSE = 64
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] ctrl_byte1,
	input wire logic spread_mode,
	input wire logic spread_type_hi,
	input wire logic spread_type_lo,
	input wire logic [3:0] watchdog_timeout_sel,
	input wire logic [13:0] fine_freq_dial,
	input wire logic processor_family_strap,
	input wire logic power_down_n,
	input wire logic spread_enable,
	input wire logic spread_center,
	input wire logic [7:0] spread_depth,
	input wire logic [13:0] active_dial,
	input wire logic system_reset_out_n,
	input wire logic watchdog_timeout_flag,
	input wire logic clocks_gate_n,
	input wire logic host_true_hold_high,
	input wire logic host_comp_oe,
	input wire logic synth_enable,
	input wire logic osc_enable,
	input wire logic mgmt_enable
);
	logic [1:0] rcnt_q, rcnt_d;
	logic [7:0] low_q, low_d;
	logic ready;
	logic [7:0] depth_tab [8] = '{8'h96, 8'h64, 8'h46, 8'h32, 8'h4B, 8'h32, 8'h23, 8'h19};
	// settle count after reset (internal sync) and reset pulse width count
	always_comb
	begin
		rcnt_d = (rcnt_q == 2'h3) ? rcnt_q : rcnt_q + 2'h1;
		low_d = system_reset_out_n ? 8'h00 : low_q + 8'h01;
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rcnt_q <= 2'h0;
			low_q <= 8'h00;
		end
		else
		begin
			rcnt_q <= rcnt_d;
			low_q <= low_d;
		end
	end
	assign ready = (rcnt_q == 2'h3);
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_spread_on:
	assert property (ready |=> spread_enable == $past(ctrl_byte1[7])) else $error("spread on");
	chk_spread_depth:
	assert property (ready |=> spread_center == $past(spread_mode) && spread_depth ==
		depth_tab[{$past(spread_mode), $past(spread_type_hi), $past(spread_type_lo)}])
		else $error("spread depth");
	chk_dial_apply:
	assert property (ready && watchdog_timeout_sel != 4'h0 && $changed(fine_freq_dial)
		|=> active_dial == $past(fine_freq_dial)) else $error("dial not applied");
	chk_pulse_width:
	assert property ($rose(system_reset_out_n) |-> low_q == 8'(RST_PULSE)) else $error("pulse");
	chk_fire_flag:
	assert property ($fell(system_reset_out_n) |-> watchdog_timeout_flag && $past(
		watchdog_timeout_sel) != 4'h0) else $error("reset without flag or armed timer");
	chk_flag_clear:
	assert property (ready && watchdog_timeout_sel == 4'h0 && $past(watchdog_timeout_sel) ==
		4'h0 |=> !watchdog_timeout_flag) else $error("flag not cleared");
	chk_pd_entry:
	assert property ($fell(clocks_gate_n) |-> !$past(power_down_n, 4)) else $error("early stop");
	chk_pd_exit:
	assert property ($rose(clocks_gate_n) |-> $past(power_down_n, 4)) else $error("early run");
	chk_diff_hold:
	assert property (host_true_hold_high |-> !host_comp_oe && !clocks_gate_n &&
		processor_family_strap) else $error("host hold");
	chk_od_off:
	assert property (!synth_enable |-> !osc_enable && !mgmt_enable && !clocks_gate_n)
		else $error("shutdown");
	cov_wd_fire: cover property ($fell(system_reset_out_n));
	cov_pd_diff: cover property ($fell(clocks_gate_n) && processor_family_strap);
	cov_pd_od: cover property ($fell(clocks_gate_n) && !processor_family_strap);
endmodule : cgwd_ctrl_chk
`default_nettype wire

// ===== verif/test_clock_gen_watchdog_powerdown.sv
// testbench: directed sequences for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module test_clock_gen_watchdog_powerdown;
	logic clk, reset_n, spread_mode, spread_type_hi, spread_type_lo, freq_revert_sel, seen;
	logic processor_family_strap, power_down_n, term_supply_good_n, spread_enable;
	logic [7:0] ctrl_byte1, spread_depth;
	logic [3:0] watchdog_timeout_sel, soft_freq_select, strap_freq, active_freq_sel;
	logic [13:0] fine_freq_dial, active_dial;
	logic spread_center, system_reset_out_n, watchdog_timeout_flag, clocks_gate_n;
	logic host_true_hold_high, host_comp_oe, synth_enable, osc_enable, mgmt_enable;
	logic clocks_running, power_good_seen;
	wire logic host_clk_in;
	int n_errors = 0;
	int checks_done = 0;
	logic [7:0] depth_tab [8] = '{8'h96, 8'h64, 8'h46, 8'h32, 8'h4B, 8'h32, 8'h23, 8'h19};
	cgwd_host_model cgwd_host_model_i (.host_clk(host_clk_in));
	// short tick and power-up counts keep the run brief
	cgwd_ctrl #(.TICK_CYCLES(100), .PWRUP_CYCLES(300)) cgwd_ctrl_i (.clk, .reset_n,
		.host_clk_in, .ctrl_byte1, .spread_mode, .spread_type_hi, .spread_type_lo,
		.watchdog_timeout_sel, .soft_freq_select, .fine_freq_dial, .freq_revert_sel,
		.strap_freq, .processor_family_strap, .power_down_n, .term_supply_good_n,
		.spread_enable, .spread_center, .spread_depth, .active_freq_sel, .active_dial,
		.system_reset_out_n, .watchdog_timeout_flag, .clocks_gate_n, .host_true_hold_high,
		.host_comp_oe, .synth_enable, .osc_enable, .mgmt_enable, .clocks_running,
		.power_good_seen);
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_vec(input string what, input logic [13:0] exp, input logic [13:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_vec
	// bounded wait on the gate (gate=1) or the reset pulse output
	task automatic wait_sig(input logic gate, input logic v, input int lim);
		int n;
		n = 0;
		while ((gate ? clocks_gate_n : system_reset_out_n) !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk_bit(gate ? "clocks_gate_n" : "system_reset_out_n", v, gate ? clocks_gate_n :
			system_reset_out_n);
	endtask : wait_sig
	task automatic do_reset(input logic strap);
		@(posedge clk);
		reset_n <= 1'b0;
		processor_family_strap <= strap;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : do_reset
	task automatic pd_cycle(input logic diff);
		@(posedge clk);
		power_down_n <= 1'b0;
		wait_sig(1'b1, 1'b0, 200);
		repeat (3) @(negedge clk);
		chk_bit("host_true_hold_high", diff, host_true_hold_high);
		chk_bit("host_comp_oe", !diff, host_comp_oe);
		chk_bit("synth_enable", diff, synth_enable);
		chk_bit("mgmt_enable", diff, mgmt_enable);
		chk_bit("osc_enable", diff, osc_enable);
		@(posedge clk);
		power_down_n <= 1'b1;
		wait_sig(1'b1, 1'b1, 400);
		chk_bit("clocks_running", 1'b1, clocks_running);
	endtask : pd_cycle
	// ************************************************************
	// sequence
	// ************************************************************
	initial
	begin
		{spread_mode, spread_type_hi, spread_type_lo, freq_revert_sel} <= 4'h0;
		{reset_n, power_down_n, term_supply_good_n, processor_family_strap} <= 4'h7;
		{ctrl_byte1, watchdog_timeout_sel, soft_freq_select, fine_freq_dial} <= 30'h0;
		strap_freq <= 4'h3;
		do_reset(1'b1);
		term_supply_good_n <= 1'b0;
		repeat (6) @(posedge clk);
		term_supply_good_n <= 1'b1;
		repeat (6) @(negedge clk);
		chk_bit("power_good_seen", 1'b1, power_good_seen);
		// every spread code, enable bit alternating
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			{spread_mode, spread_type_hi, spread_type_lo} <= 3'(i);
			ctrl_byte1 <= {i[0], 7'h55};
			repeat (2) @(negedge clk);
			chk_vec("spread_depth", {6'h00, depth_tab[i]}, {6'h00, spread_depth});
			chk_bit("spread_enable", i[0], spread_enable);
			chk_bit("spread_center", i[2], spread_center);
		end
		// dial change armed, then disarmed before expiry
		@(posedge clk);
		watchdog_timeout_sel <= 4'h1;
		repeat (3) @(posedge clk);
		fine_freq_dial <= 14'h2ABC;
		repeat (2) @(negedge clk);
		chk_vec("active_dial", 14'h2ABC, active_dial);
		repeat (50) @(posedge clk);
		watchdog_timeout_sel <= 4'h0;
		seen = 1'b1;
		repeat (150) @(negedge clk) seen &= system_reset_out_n;
		chk_bit("system_reset_out_n", 1'b1, seen);
		chk_vec("active_dial", 14'h2ABC, active_dial);
		// soft select change expires; both revert choices
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clk);
			freq_revert_sel <= r[0];
			soft_freq_select <= 4'h5; // timer off, so this change arms nothing
			repeat (3) @(posedge clk);
			watchdog_timeout_sel <= 4'h2;
			repeat (3) @(posedge clk);
			soft_freq_select <= 4'hA;
			repeat (150) @(negedge clk);
			chk_bit("system_reset_out_n", 1'b1, system_reset_out_n);
			wait_sig(1'b0, 1'b0, 100);
			chk_bit("watchdog_timeout_flag", 1'b1, watchdog_timeout_flag);
			wait_sig(1'b0, 1'b1, 80);
			repeat (2) @(negedge clk);
			chk_vec("active_freq_sel", r ? 14'h5 : 14'h3, {10'h0, active_freq_sel});
			@(posedge clk);
			watchdog_timeout_sel <= 4'h0;
			repeat (3) @(negedge clk);
			chk_bit("watchdog_timeout_flag", 1'b0, watchdog_timeout_flag);
		end
		pd_cycle(1'b1);
		do_reset(1'b0);
		pd_cycle(1'b0);
		end_sim();
	end
	// watchdog: the sequence needs well under 5000 cycles
	initial
	begin
		#200000;
		n_errors++;
		end_sim();
	end
endmodule : test_clock_gen_watchdog_powerdown
bind cgwd_ctrl cgwd_ctrl_chk #(.RST_PULSE(RST_PULSE)) cgwd_ctrl_chk_i (.clk, .reset_n,
	.ctrl_byte1, .spread_mode, .spread_type_hi, .spread_type_lo, .watchdog_timeout_sel,
	.fine_freq_dial, .processor_family_strap, .power_down_n, .spread_enable, .spread_center,
	.spread_depth, .active_dial, .system_reset_out_n, .watchdog_timeout_flag, .clocks_gate_n,
	.host_true_hold_high, .host_comp_oe, .synth_enable, .osc_enable, .mgmt_enable);
`default_nettype wire
